// ---- ddi_func_sel.sv ----
// Digital input function select and command decode for eight terminals.
// Assumes terminal levels arrive asynchronously; writes come from the same clock.
`timescale 1ns/1ns
`default_nettype none
module ddi_func_sel
   import ddi_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic [NUM_TERM-1:0] term_in,
   input  wire ddi_wr_t             sel_wr,
   input  wire logic                closed_loop,
   input  wire logic                multi_setup,
   input  wire logic                brake_cfg_ok,
   input  wire logic                trip_locked,
   input  wire logic                alarm_set,
   input  wire logic                off_stop_key,
   output logic                     sel_wr_err,
   output ddi_cmd_t                 cmd,
   output logic                     alarm_pending,
   output logic                     safety_out,
   output logic [NUM_TERM*5-1:0]    sel_rd
);
   logic [NUM_TERM-1:0] sync1_q, sync2_q, lvl_q;
   logic [4:0]          sel_q [NUM_TERM];
   logic                err_q, alarm_q, fault_q, safe_q;
   ddi_cmd_t            cmd_q, cmd_d;
   logic [1:0]          setup_hold_q;

   // Legal code check per terminal, gaps excluded
   function automatic logic code_ok(input logic [2:0] t, input logic [4:0] c);
      logic ok;
      ok = 1'b0;
      unique case (t)
         3'h0: ok = (c <= MAX_T0) && (c != 5'h0d) && (c != 5'h0e);
         3'h1: ok = (c <= MAX_T1) && (c != 5'h0e) && (c != 5'h0f);
         3'h2: ok = (c <= MAX_T2);
         3'h3: ok = (c <= MAX_T3);
         3'h4: ok = (c <= MAX_T4);
         3'h5: ok = (c <= MAX_T5) && (c != 5'h12);
         3'h6: ok = (c <= MAX_T6);
         3'h7: ok = (c <= MAX_T7);
      endcase
      return ok;
   endfunction

   function automatic logic [4:0] rst_code(input int t);
      logic [4:0] r;
      r = RST_T0;
      unique case (t)
         0: r = RST_T0;
         1: r = RST_T1;
         2: r = RST_T2;
         3: r = RST_T3;
         4: r = RST_T4;
         5: r = RST_T5;
         6: r = RST_T6;
         default: r = RST_T7;
      endcase
      return r;
   endfunction

   // Write decode
   wire [8:0] wr_idx9 = sel_wr.param - PAR_FIRST;
   wire       wr_hit  = sel_wr.valid && (sel_wr.param >= PAR_FIRST)
                        && (wr_idx9 < 9'h008);
   wire [2:0] wr_idx  = wr_idx9[2:0];
   wire       wr_good = wr_hit && code_ok(wr_idx, sel_wr.code);

   // Selectors
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_TERM; i++) begin
         if (!rst_b) begin
            sel_q[i] <= rst_code(i);
         end else if (wr_good && (wr_idx == 3'(i))) begin
            sel_q[i] <= sel_wr.code;
         end
      end
   end

   // Write error flag
   always_ff @(posedge clk) begin
      if (!rst_b) err_q <= 1'b0;
      else        err_q <= sel_wr.valid && !wr_good;
   end

   // Two-stage synchroniser then level history, running through reset
   // Pin level is settled at release, so no false edge follows reset
   // Reset must span at least three clock edges for this to hold
   always_ff @(posedge clk) begin
      sync1_q <= term_in;
      sync2_q <= sync1_q;
      lvl_q   <= sync2_q;
   end

   wire [NUM_TERM-1:0] rise = sync2_q & ~lvl_q;
   wire [NUM_TERM-1:0] fall = ~sync2_q & lvl_q;
   wire [NUM_TERM-1:0] lvl  = sync2_q;

   // Per-terminal function hits; none codes hit nothing
   wire [NUM_TERM-1:0] is_rst, is_frzr, is_frzo;
   for (genvar g = 0; g < NUM_TERM; g++) begin : g_gen
      wire gen_t = (g != 2) && (g != 3) && (g != 4);
      assign is_rst[g]  = gen_t && (sel_q[g] == FC_RESET);
      assign is_frzr[g] = gen_t && (sel_q[g] == FC_FRZ_REF);
      assign is_frzo[g] = gen_t && (sel_q[g] == FC_FRZ_OUT);
   end

   // Coast terminal (27), terminal 19 and start terminal 18 decode
   wire t27_coast = (sel_q[4] == FC_COAST_T27) && !lvl[4];
   wire t27_rc    = (sel_q[4] == FC_RSTCOAST_T27);
   wire t27_dcb   = (sel_q[4] == FC_DCB_T27) && !lvl[4];
   wire t27_safe  = (sel_q[4] == FC_SAFE_T27) && !lvl[4];
   wire t19_rev   = (sel_q[3] == FC_REV_T19) && lvl[3] && !closed_loop;
   wire t19_rs    = (sel_q[3] == FC_REVSTART_T19) && lvl[3] && !closed_loop;
   wire t19_dcb   = (sel_q[3] == FC_DCB_T19) && !lvl[3];
   wire t18_run   = (sel_q[2] == FC_START_T18) && lvl[2];

   // Setup and preset bits
   wire su_lo = ((sel_q[0] == FC_CODE4) && lvl[0]) || ((sel_q[5] == FC_CODE4) && lvl[5])
              || ((sel_q[6] == FC_CODE4) && lvl[6]);
   wire su_hi = ((sel_q[1] == FC_CODE4) && lvl[1]) || ((sel_q[5] == FC_CODE5) && lvl[5])
              || ((sel_q[7] == FC_CODE4) && lvl[7]);
   wire pr_lo = ((sel_q[0] == FC_CODE6) && lvl[0]) || ((sel_q[5] == FC_CODE7) && lvl[5])
              || ((sel_q[6] == FC_CODE6) && lvl[6]);
   wire pr_hi = ((sel_q[1] == FC_CODE6) && lvl[1]) || ((sel_q[5] == FC_CODE8) && lvl[5])
              || ((sel_q[7] == FC_CODE6) && lvl[7]);

   wire rst_evt = (|(is_rst & rise)) || (t27_rc && fall[4]);

   // Command assembly
   always_comb begin
      cmd_d             = '0;
      cmd_d.reset_pulse = rst_evt;
      cmd_d.coast       = t27_coast || t27_safe || (t27_rc && !lvl[4]);
      cmd_d.dc_brake    = (t27_dcb || t19_dcb) && brake_cfg_ok;
      cmd_d.ext_fault   = fault_q;
      cmd_d.run         = t18_run || t19_rs;
      cmd_d.reverse     = t19_rev || t19_rs;
      cmd_d.freeze_ref  = |(is_frzr & lvl);
      cmd_d.freeze_out  = |(is_frzo & lvl);
      cmd_d.setup_sel   = multi_setup ? {su_hi, su_lo} : setup_hold_q;
      cmd_d.preset_sel  = {pr_hi, pr_lo};
   end

   // Command, alarm and fault registers; set wins over clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cmd_q        <= '0;
         alarm_q      <= 1'b0;
         fault_q      <= 1'b0;
         safe_q       <= 1'b0;
         setup_hold_q <= 2'h0;
      end else begin
         cmd_q        <= cmd_d;
         setup_hold_q <= cmd_d.setup_sel;
         if (alarm_set || t27_safe)             alarm_q <= 1'b1;
         else if (rst_evt && !trip_locked)      alarm_q <= 1'b0;
         if (t27_safe)                          fault_q <= 1'b1;
         else if (rst_evt || off_stop_key)      fault_q <= 1'b0;
         safe_q       <= t27_safe || fault_q;
      end
   end

   assign cmd           = cmd_q;
   assign alarm_pending = alarm_q;
   assign safety_out    = safe_q;
   assign sel_wr_err    = err_q;
   for (genvar g = 0; g < NUM_TERM; g++) begin : g_rd
      assign sel_rd[g*5 +: 5] = sel_q[g];
   end

   // Checks
   coast_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      (sel_q[4] == FC_COAST_T27 && !sync2_q[4]) |=> cmd.coast)
      else $error("coast not asserted");
   start_lvl_a: assert property (@(posedge clk) disable iff (!rst_b)
      (sel_q[2] == FC_START_T18) |=> (cmd.run == $past(sync2_q[2]) || $past(t19_rs)))
      else $error("run mismatch");
   rev_cl_a: assert property (@(posedge clk) disable iff (!rst_b)
      closed_loop && $stable(closed_loop) |=> !cmd.reverse)
      else $error("reverse in closed loop");
   brake_cfg_a: assert property (@(posedge clk) disable iff (!rst_b)
      !brake_cfg_ok |=> !cmd.dc_brake)
      else $error("brake without config");
   bad_code_a: assert property (@(posedge clk) disable iff (!rst_b)
      (sel_wr.valid && !wr_good) |=> (sel_rd == $past(sel_rd)) && sel_wr_err)
      else $error("bad code accepted");
   sync_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(sync2_q[0]) |-> $past(term_in[0], 2))
      else $error("sync depth wrong");
   safe_fault_a: assert property (@(posedge clk) disable iff (!rst_b)
      t27_safe |=> cmd_d.ext_fault ##1 safety_out)
      else $error("fault not raised");
   reset_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
      (sel_q[0] == FC_RESET && sync2_q[0] && !lvl_q[0]) |=> cmd.reset_pulse)
      else $error("reset edge missed");
   no_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
      (sync2_q == lvl_q) |=> !cmd.reset_pulse)
      else $error("reset pulse without edge");
   none_ign_a: assert property (@(posedge clk) disable iff (!rst_b)
      (sel_q[0] == FC_NONE && sync2_q[0] != lvl_q[0] && sync2_q[7:1] == lvl_q[7:1])
      |=> !cmd.reset_pulse)
      else $error("none terminal acted");
   cov_reset: cover property (@(posedge clk) disable iff (!rst_b) cmd.reset_pulse);
   cov_safe: cover property (@(posedge clk) disable iff (!rst_b) $rose(safety_out));
   cov_setup: cover property (@(posedge clk) disable iff (!rst_b) cmd.setup_sel == 2'h3);
   cov_err: cover property (@(posedge clk) disable iff (!rst_b) sel_wr_err);
endmodule // ddi_func_sel
`default_nettype wire

// ---- ddi_pkg.sv ----
// Package for the digital input function select block: codes, resets, structs.
// Assumes a single clock domain; codes match the serial port values.
package ddi_pkg;
   localparam int NUM_TERM = 8;
   localparam logic [4:0] FC_NONE = 5'h00;
   localparam logic [4:0] FC_RESET = 5'h01;
   localparam logic [4:0] FC_FRZ_REF = 5'h02;
   localparam logic [4:0] FC_FRZ_OUT = 5'h03;
   localparam logic [4:0] FC_START_T18 = 5'h01;
   localparam logic [4:0] FC_REV_T19 = 5'h01;
   localparam logic [4:0] FC_REVSTART_T19 = 5'h02;
   localparam logic [4:0] FC_DCB_T19 = 5'h03;
   localparam logic [4:0] FC_COAST_T27 = 5'h00;
   localparam logic [4:0] FC_RSTCOAST_T27 = 5'h01;
   localparam logic [4:0] FC_DCB_T27 = 5'h02;
   localparam logic [4:0] FC_SAFE_T27 = 5'h03;
   localparam logic [4:0] FC_CODE4 = 5'h04;
   localparam logic [4:0] FC_CODE5 = 5'h05;
   localparam logic [4:0] FC_CODE6 = 5'h06;
   localparam logic [4:0] FC_CODE7 = 5'h07;
   localparam logic [4:0] FC_CODE8 = 5'h08;
   localparam logic [8:0] PAR_FIRST = 9'h12c;
   // Highest legal code per terminal 0..7
   localparam logic [4:0] MAX_T0 = 5'h0f;
   localparam logic [4:0] MAX_T1 = 5'h10;
   localparam logic [4:0] MAX_T2 = 5'h02;
   localparam logic [4:0] MAX_T3 = 5'h03;
   localparam logic [4:0] MAX_T4 = 5'h03;
   localparam logic [4:0] MAX_T5 = 5'h14;
   localparam logic [4:0] MAX_T6 = 5'h0f;
   localparam logic [4:0] MAX_T7 = 5'h0f;
   // Factory settings
   localparam logic [4:0] RST_T0 = 5'h01;
   localparam logic [4:0] RST_T1 = 5'h02;
   localparam logic [4:0] RST_T2 = 5'h01;
   localparam logic [4:0] RST_T3 = 5'h01;
   localparam logic [4:0] RST_T4 = 5'h03;
   localparam logic [4:0] RST_T5 = 5'h0c;
   localparam logic [4:0] RST_T6 = 5'h00;
   localparam logic [4:0] RST_T7 = 5'h00;

   typedef struct packed {
      logic       valid;
      logic [8:0] param;
      logic [4:0] code;
   } ddi_wr_t;

   typedef struct packed {
      logic       reset_pulse;
      logic       coast;
      logic       dc_brake;
      logic       ext_fault;
      logic       run;
      logic       reverse;
      logic       freeze_ref;
      logic       freeze_out;
      logic [1:0] setup_sel;
      logic [1:0] preset_sel;
   } ddi_cmd_t;
endpackage

// ---- ddi_term_src.sv ----
// Model of the contacts or controller that drive the eight terminals.
// Assumes the bench sets levels just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module ddi_term_src
   import ddi_pkg::*;
(
   input  wire logic                rs_mode,
   input  wire logic [NUM_TERM-1:0] lvl,
   output logic [NUM_TERM-1:0]      term_in
);
   // Start contact stays open while reverse-and-start is in use
   always_comb begin
      term_in = lvl;
      if (rs_mode) begin
         term_in[2] = 1'b0;
      end
   end
endmodule // ddi_term_src
`default_nettype wire

// ---- drive_digital_input_function_select_tb.sv ----
// Bench for the terminal function select: writes, levels, edges, alarms.
// Assumes ddi_pkg, ddi_func_sel and ddi_term_src are compiled first.
`timescale 1ns/1ns
`default_nettype none
module drive_digital_input_function_select_tb;
   import ddi_pkg::*;
   logic                  clk, rst_b, closed_loop, multi_setup, brake_cfg_ok;
   logic                  trip_locked, alarm_set, off_stop_key, rs_mode;
   logic                  sel_wr_err, alarm_pending, safety_out;
   logic [NUM_TERM-1:0]   lvl, term_in;
   logic [NUM_TERM*5-1:0] sel_rd;
   ddi_wr_t               sel_wr;
   ddi_cmd_t              cmd;
   int                    bad_count, tests_run, ones;
   // Free-running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ddi_term_src src (.rs_mode(rs_mode), .lvl(lvl), .term_in(term_in));
   ddi_func_sel dut (.clk(clk), .rst_b(rst_b), .term_in(term_in), .sel_wr(sel_wr),
      .closed_loop(closed_loop), .multi_setup(multi_setup), .brake_cfg_ok(brake_cfg_ok),
      .trip_locked(trip_locked), .alarm_set(alarm_set), .off_stop_key(off_stop_key),
      .sel_wr_err(sel_wr_err), .cmd(cmd), .alarm_pending(alarm_pending),
      .safety_out(safety_out), .sel_rd(sel_rd));
   // Step to just after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One-cycle selector write, error flag looked at in the next cycle
   task automatic wr(input logic [8:0] p, input logic [4:0] c, input logic err);
      sel_wr = '{1'b1, p, c};
      cyc(1);
      sel_wr.valid = 1'b0;
      chk(sel_wr_err, err);
      cyc(1);
   endtask
   task automatic set(input logic [7:0] v);
      lvl = v;
      cyc(5);
   endtask
   // Count reset pulses after a level change
   task automatic pulses(input logic [7:0] v);
      lvl = v;
      ones = 0;
      repeat (6) begin
         cyc(1);
         if (cmd.reset_pulse === 1'b1) ones++;
      end
   endtask
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, far beyond the roughly 190 cycles needed
   initial begin
      #40000;
      bad_count++;
      final_report();
   end
   initial begin
      bad_count = 0;
      tests_run = 0;
      {rst_b, rs_mode, closed_loop, multi_setup, brake_cfg_ok} = '0;
      {trip_locked, alarm_set, off_stop_key} = '0;
      lvl = 8'h10;
      sel_wr = '0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      cyc(4);
      chk(sel_rd, {5'h00, 5'h00, 5'h0c, 5'h03, 5'h01, 5'h01, 5'h02, 5'h01});
      chk(cmd, '0);
      wr(9'h12c, 5'h0d, 1'b1);
      wr(9'h130, 5'h04, 1'b1);
      wr(9'h134, 5'h01, 1'b1);
      wr(9'h12e, 5'h02, 1'b0);
      chk(sel_rd[14:10], 5'h02);
      wr(9'h12e, 5'h01, 1'b0);
      set(8'h14);
      chk(cmd.run, 1'b1);
      set(8'h18);
      chk({cmd.run, cmd.reverse}, 2'b01);
      closed_loop = 1'b1;
      cyc(4);
      chk(cmd.reverse, 1'b0);
      closed_loop = 1'b0;
      wr(9'h12f, 5'h02, 1'b0);
      rs_mode = 1'b1;
      cyc(4);
      chk({cmd.run, cmd.reverse}, 2'b11);
      closed_loop = 1'b1;
      cyc(4);
      chk({cmd.run, cmd.reverse}, 2'b00);
      {closed_loop, rs_mode} = 2'b00;
      wr(9'h12f, 5'h01, 1'b0);
      set(8'h00);
      chk({cmd.coast, cmd.ext_fault, safety_out, alarm_pending}, 4'hf);
      set(8'h10);
      chk({cmd.coast, cmd.ext_fault}, 2'b01);
      trip_locked = 1'b1;
      pulses(8'h11);
      chk(ones, 1);
      chk({alarm_pending, cmd.ext_fault}, 2'b10);
      trip_locked = 1'b0;
      pulses(8'h10);
      chk(ones, 0);
      pulses(8'h11);
      chk({ones[0], alarm_pending}, 2'b10);
      set(8'h01);
      set(8'h11);
      off_stop_key = 1'b1;
      cyc(2);
      off_stop_key = 1'b0;
      cyc(4);
      chk({cmd.ext_fault, safety_out}, 2'b00);
      wr(9'h130, 5'h00, 1'b0);
      set(8'h01);
      chk(cmd.coast, 1'b1);
      wr(9'h130, 5'h01, 1'b0);
      pulses(8'h11);
      chk(ones, 0);
      pulses(8'h01);
      chk({ones[1:0], cmd.coast}, 3'b011);
      wr(9'h130, 5'h02, 1'b0);
      cyc(4);
      chk({cmd.dc_brake, cmd.coast}, 2'b00);
      brake_cfg_ok = 1'b1;
      cyc(4);
      chk(cmd.dc_brake, 1'b1);
      set(8'h11);
      chk(cmd.dc_brake, 1'b0);
      wr(9'h130, 5'h03, 1'b0);
      wr(9'h12c, 5'h00, 1'b0);
      pulses(8'h10);
      pulses(8'hd1);
      chk(ones, 0);
      chk(cmd, '0);
      wr(9'h12c, 5'h04, 1'b0);
      wr(9'h12d, 5'h04, 1'b0);
      multi_setup = 1'b1;
      set(8'h11);
      chk(cmd.setup_sel, 2'b01);
      set(8'h12);
      chk(cmd.setup_sel, 2'b10);
      set(8'h13);
      chk(cmd.setup_sel, 2'b11);
      // Multi-setup off: the last setup choice is kept
      multi_setup = 1'b0;
      set(8'h10);
      chk(cmd.setup_sel, 2'b11);
      wr(9'h12c, 5'h06, 1'b0);
      wr(9'h131, 5'h08, 1'b0);
      set(8'h21);
      chk(cmd.preset_sel, 2'b11);
      set(8'h30);
      chk(cmd.preset_sel, 2'b10);
      wr(9'h12c, 5'h03, 1'b0);
      wr(9'h12d, 5'h02, 1'b0);
      set(8'h13);
      chk({cmd.freeze_ref, cmd.freeze_out}, 2'b11);
      final_report();
   end
endmodule // drive_digital_input_function_select_tb
`default_nettype wire
